// ---- design/gtb_pkg.sv ----
// ---------------------------------------------------------------------------
// gtb_pkg: constants and types shared by the six-channel general timer block
// ---------------------------------------------------------------------------
// assumes a 40 MHz mclk, a synchronous active-high reset and a plain
// register port with 8-bit byte addresses and 16-bit data in the low bits.
package gtb_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int GTB_NCH = 6;
  localparam int GTB_CW = 16;
  localparam int GTB_AW = 8;
  localparam int GTB_DW = 32;

  // ---------------------------------------------------------------------------
  // register map: channel i sits at byte address 0x10*i
  // ---------------------------------------------------------------------------
  localparam logic [3:0] GTB_TMR_OFS = 4'h0;    // timer / reload register
  localparam logic [3:0] GTB_MODE_OFS = 4'h4;   // mode register
  localparam logic [7:0] GTB_START_ADDR = 8'h60;  // count start flags, bit i = channel i

  // ---------------------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] GTB_CNT_RST = 16'h0000;
  localparam logic [15:0] GTB_CNT_MAX = 16'hffff;
  localparam logic [15:0] GTB_MODE_RST = 16'h0000;
  localparam logic [5:0] GTB_START_RST = 6'h00;
  localparam logic [1:0] GTB_EDGES_DONE = 2'd2;  // edges seen before a result is valid

  // ---------------------------------------------------------------------------
  // prescaler ratios (free-running counter, ticks once per ratio)
  // ---------------------------------------------------------------------------
  localparam logic [4:0] GTB_DIV8_LAST = 5'd7;
  localparam logic [4:0] GTB_DIV32_LAST = 5'd31;

  // ---------------------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    GTB_M_TIMER = 2'b00,
    GTB_M_EVENT = 2'b01,
    GTB_M_MEAS  = 2'b10,
    GTB_M_RSVD  = 2'b11
  } gtb_opmode_t;

  localparam logic [1:0] GTB_CLK_DIV1 = 2'b00;
  localparam logic [1:0] GTB_CLK_DIV8 = 2'b01;
  localparam logic [1:0] GTB_CLK_DIV32 = 2'b10;
  localparam logic [1:0] GTB_CLK_SUB32 = 2'b11;

  localparam logic [1:0] GTB_EDGE_FALL = 2'b00;
  localparam logic [1:0] GTB_EDGE_RISE = 2'b01;

  typedef struct packed {
    logic [4:0] rsvd;        // reads as zero
    logic result_valid;      // read only: two edges seen in measurement
    logic meas_rise;         // period: 1 rising edges, 0 falling edges
    logic meas_width;        // 1 width measurement, 0 period measurement
    logic [1:0] clk_sel;     // internal count source
    logic ovf;               // read only: measurement overflow flag
    logic evt_src;           // event mode: 0 pin, 1 neighbour underflow
    logic [1:0] edge_sel;    // event mode: 00 fall, 01 rise, 1x both
    gtb_opmode_t opmode;
  } gtb_mode_t;

  // internal count-source enables, one mclk wide each except div1, which stays high
  typedef struct packed {
    logic div1;
    logic div8;
    logic div32;
    logic sub32;
  } gtb_ticks_t;

endpackage

// ---- design/gtb_prescale.sv ----
// ---------------------------------------------------------------------------
// gtb_prescale: count-source enables for all timer channels
// ---------------------------------------------------------------------------
// assumes subclk is an asynchronous slow clock pin, far slower than mclk;
// it is sampled here, never used as a clock.
`timescale 1ns/1ps

module gtb_prescale
  import gtb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic subclk,
  output gtb_ticks_t ticks
);

  logic [4:0] div_q;
  logic [4:0] sub_div_q;
  logic sub_s1_q;
  logic sub_s2_q;
  logic sub_s3_q;

  // ---------------------------------------------------------------------------
  // main clock divider
  // ---------------------------------------------------------------------------
  // one shared counter keeps div8 and div32 phase-aligned
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q <= 5'd0;
    end else begin
      div_q <= div_q + 5'd1;
    end
  end

  // ---------------------------------------------------------------------------
  // subclock sampling and divide by 32
  // ---------------------------------------------------------------------------
  // two flops before use; the third only remembers the last level for edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      sub_s1_q <= subclk;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sub_div_q <= 5'd0;
    end else if (sub_s2_q && !sub_s3_q) begin
      sub_div_q <= sub_div_q + 5'd1;
    end
  end

  // ---------------------------------------------------------------------------
  // registered enables
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ticks <= '0;
    end else begin
      ticks.div1 <= 1'b1;
      ticks.div8 <= (div_q[2:0] == GTB_DIV8_LAST[2:0]);
      ticks.div32 <= (div_q == GTB_DIV32_LAST);
      ticks.sub32 <= sub_s2_q && !sub_s3_q && (sub_div_q == GTB_DIV32_LAST);
    end
  end

endmodule

// ---- design/gtb_timer.sv ----
// ---------------------------------------------------------------------------
// gtb_timer: six 16-bit timer channels with timer, event and measure modes
// ---------------------------------------------------------------------------
// assumes a bus master that issues one-cycle read or write strobes and takes
// read data in the cycle after the read strobe; input pins are asynchronous.
//
// Notes on behaviour
// - six identical channels, each with a mode register; low two bits pick mode.
// - timer mode counts down on div1, div8, div32 or subclock div32.
// - timer and event modes count down, reload on underflow, raise interrupt.
// - loaded value n underflows every n+1 counted events.
// - the count start flag starts counting when set, stops when cleared.
// - timer and event modes read back the live counter.
// - a write while stopped loads both reload register and counter.
// - a write while counting loads only the reload register; the counter takes it too when it lands on an underflow cycle.
// - event mode counts pin pulses or a neighbour timer's underflow.
// - event mode counts rising, falling or both pin edges.
// - measurement mode counts up on the chosen internal clock.
// - each effective edge copies the counter to reload, counter restarts at zero.
// - each effective edge interrupts, except the first after start.
// - measurement overflow interrupts and sets the overflow flag.
// - writing the mode register while started clears the overflow flag.
// - measurement mode reads back the reload register, the last result.
// - the measured result is undefined before the second effective edge.
// - measurement mode ignores writes to the timer register.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module gtb_timer
  import gtb_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [GTB_AW-1:0] addr,
  input wire logic [GTB_DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [GTB_DW-1:0] rdata,
  input wire logic subclk,
  input wire logic [GTB_NCH-1:0] event_input_pin,
  output logic [GTB_NCH-1:0] irq_req
);

  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a, input int ch, input logic [3:0] ofs);
    return (a[7:4] == 4'(ch)) && (a[3:0] == ofs);
  endfunction

  function automatic logic clk_pick(input gtb_ticks_t t, input logic [1:0] sel);
    logic r;
    r = t.div1;
    if (sel == GTB_CLK_DIV8) begin
      r = t.div8;
    end else if (sel == GTB_CLK_DIV32) begin
      r = t.div32;
    end else if (sel == GTB_CLK_SUB32) begin
      r = t.sub32;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  gtb_ticks_t ticks;
  gtb_mode_t mode_q [GTB_NCH];
  logic [GTB_CW-1:0] cnt_q [GTB_NCH];
  logic [GTB_CW-1:0] reload_q [GTB_NCH];
  logic [1:0] edges_q [GTB_NCH];
  logic [GTB_NCH-1:0] start_q;
  logic [GTB_NCH-1:0] ovf_q;
  logic [GTB_NCH-1:0] uf_q;
  logic [GTB_NCH-1:0] irq_q;
  logic [GTB_NCH-1:0] pin_s1_q;
  logic [GTB_NCH-1:0] pin_s2_q;
  logic [GTB_NCH-1:0] pin_s3_q;
  logic [GTB_DW-1:0] rdata_q;

  logic [GTB_NCH-1:0] rise_w;
  logic [GTB_NCH-1:0] fall_w;
  logic [GTB_NCH-1:0] tick_w;
  logic [GTB_NCH-1:0] edge_w;
  logic [GTB_NCH-1:0] uf_w;
  logic [GTB_NCH-1:0] ovf_ev_w;
  logic [GTB_NCH-1:0] down_w;
  logic [GTB_NCH-1:0] meas_w;
  logic [GTB_NCH-1:0] wr_tmr_w;
  logic [GTB_NCH-1:0] wr_mode_w;
  logic wr_start_w;

  gtb_prescale u_prescale (
    .mclk(mclk),
    .rst(rst),
    .subclk(subclk),
    .ticks(ticks)
  );

  // ---------------------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------------------
  // pulses narrower than one mclk period may be missed
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= event_input_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign rise_w = pin_s2_q & ~pin_s3_q;
  assign fall_w = ~pin_s2_q & pin_s3_q;

  // ---------------------------------------------------------------------------
  // per-channel decode of sources, edges and events
  // ---------------------------------------------------------------------------
  always_comb begin
    wr_start_w = wr_stb && (addr == GTB_START_ADDR);
    for (int i = 0; i < GTB_NCH; i++) begin
      wr_tmr_w[i] = wr_stb && reg_hit(addr, i, GTB_TMR_OFS);
      wr_mode_w[i] = wr_stb && reg_hit(addr, i, GTB_MODE_OFS);
      down_w[i] = (mode_q[i].opmode == GTB_M_TIMER) || (mode_q[i].opmode == GTB_M_EVENT);
      meas_w[i] = (mode_q[i].opmode == GTB_M_MEAS);
      // measurement edges: both for width, one polarity for period
      if (mode_q[i].meas_width) begin
        edge_w[i] = rise_w[i] | fall_w[i];
      end else if (mode_q[i].meas_rise) begin
        edge_w[i] = rise_w[i];
      end else begin
        edge_w[i] = fall_w[i];
      end
      edge_w[i] = edge_w[i] && meas_w[i] && start_q[i];
      // count source; registered underflow of the lower neighbour avoids a loop
      if (mode_q[i].opmode == GTB_M_EVENT) begin
        if (mode_q[i].evt_src) begin
          tick_w[i] = uf_q[(i + GTB_NCH - 1) % GTB_NCH];
        end else if (mode_q[i].edge_sel == GTB_EDGE_FALL) begin
          tick_w[i] = fall_w[i];
        end else if (mode_q[i].edge_sel == GTB_EDGE_RISE) begin
          tick_w[i] = rise_w[i];
        end else begin
          tick_w[i] = rise_w[i] | fall_w[i];
        end
      end else begin
        tick_w[i] = clk_pick(ticks, mode_q[i].clk_sel);
      end
      tick_w[i] = tick_w[i] && start_q[i];
      uf_w[i] = down_w[i] && tick_w[i] && (cnt_q[i] == GTB_CNT_RST);
      ovf_ev_w[i] = meas_w[i] && tick_w[i] && !edge_w[i] && (cnt_q[i] == GTB_CNT_MAX);
    end
  end

  // ---------------------------------------------------------------------------
  // start flags and mode registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      start_q <= GTB_START_RST;
    end else if (wr_start_w) begin
      start_q <= wdata[GTB_NCH-1:0];
    end
  end

  // six independent mode registers, read-only bits stored as zero
  always_ff @(posedge mclk) begin
    for (int i = 0; i < GTB_NCH; i++) begin
      if (rst) begin
        mode_q[i] <= gtb_mode_t'(GTB_MODE_RST);
      end else if (wr_mode_w[i]) begin
        mode_q[i] <= gtb_mode_t'(wdata[GTB_CW-1:0]);
        mode_q[i].ovf <= 1'b0;
        mode_q[i].result_valid <= 1'b0;
        mode_q[i].rsvd <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    for (int i = 0; i < GTB_NCH; i++) begin
      if (rst) begin
        cnt_q[i] <= GTB_CNT_RST;
      end else if (down_w[i]) begin
        if (wr_tmr_w[i] && !start_q[i]) begin
          cnt_q[i] <= wdata[GTB_CW-1:0];
        end else if (uf_w[i]) begin
          // a write landing on the underflow cycle is taken at once
          cnt_q[i] <= wr_tmr_w[i] ? wdata[GTB_CW-1:0] : reload_q[i];
        end else if (tick_w[i]) begin
          cnt_q[i] <= cnt_q[i] - 16'd1;
        end
      end else if (meas_w[i]) begin
        if (edge_w[i]) begin
          cnt_q[i] <= GTB_CNT_RST;
        end else if (tick_w[i]) begin
          cnt_q[i] <= cnt_q[i] + 16'd1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // reload registers
  // ---------------------------------------------------------------------------
  // in measurement mode only the edge capture writes here, never software
  always_ff @(posedge mclk) begin
    for (int i = 0; i < GTB_NCH; i++) begin
      if (rst) begin
        reload_q[i] <= GTB_CNT_RST;
      end else if (down_w[i] && wr_tmr_w[i]) begin
        reload_q[i] <= wdata[GTB_CW-1:0];
      end else if (edge_w[i]) begin
        reload_q[i] <= cnt_q[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // edge count since start, overflow flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    for (int i = 0; i < GTB_NCH; i++) begin
      if (rst || !start_q[i]) begin
        edges_q[i] <= 2'd0;
      end else if (edge_w[i] && edges_q[i] != GTB_EDGES_DONE) begin
        edges_q[i] <= edges_q[i] + 2'd1;
      end
    end
  end

  // an overflow in the clearing cycle keeps the flag set
  always_ff @(posedge mclk) begin
    for (int i = 0; i < GTB_NCH; i++) begin
      if (rst) begin
        ovf_q[i] <= 1'b0;
      end else if (ovf_ev_w[i]) begin
        ovf_q[i] <= 1'b1;
      end else if (wr_mode_w[i] && start_q[i]) begin
        ovf_q[i] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt requests and underflow chain
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_q <= '0;
      uf_q <= '0;
    end else begin
      uf_q <= uf_w;
      for (int i = 0; i < GTB_NCH; i++) begin
        irq_q[i] <= uf_w[i] || ovf_ev_w[i]
          || (edge_w[i] && edges_q[i] != 2'd0);
      end
    end
  end

  assign irq_req = irq_q;

  // ---------------------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------------------
  // data stand for one cycle only; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (rd_stb) begin
        if (addr == GTB_START_ADDR) begin
          rdata_q <= {26'd0, start_q};
        end else begin
          for (int i = 0; i < GTB_NCH; i++) begin
            if (reg_hit(addr, i, GTB_TMR_OFS)) begin
              rdata_q <= {16'd0, meas_w[i] ? reload_q[i] : cnt_q[i]};
            end else if (reg_hit(addr, i, GTB_MODE_OFS)) begin
              rdata_q <= {16'd0, mode_q[i].rsvd, (edges_q[i] == GTB_EDGES_DONE),
                          mode_q[i][9:6], ovf_q[i], mode_q[i][4:0]};
            end
          end
        end
      end
    end
  end

  assign rdata = rdata_q;

  // ---------------------------------------------------------------------------
  // checks on channel 0, and on channel 1 where edges on its pin are exercised
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_underflow_reload;
    down_w[0] && uf_w[0] && !wr_tmr_w[0] |=> irq_req[0] && cnt_q[0] == $past(reload_q[0]);
  endproperty
  a_underflow_reload: assert property (p_underflow_reload)
    else $error("underflow did not reload and interrupt");

  property p_stopped_write;
    down_w[0] && wr_tmr_w[0] && !start_q[0]
      |=> cnt_q[0] == $past(wdata[15:0]) && reload_q[0] == $past(wdata[15:0]);
  endproperty
  a_stopped_write: assert property (p_stopped_write)
    else $error("stopped write did not load counter and reload");

  property p_running_write;
    down_w[0] && wr_tmr_w[0] && start_q[0] && !uf_w[0] |=> reload_q[0] == $past(wdata[15:0])
      && cnt_q[0] == ($past(tick_w[0]) ? $past(cnt_q[0]) - 16'd1 : $past(cnt_q[0]));
  endproperty
  a_running_write: assert property (p_running_write)
    else $error("running write disturbed the counter");

  property p_stopped_hold;
    !start_q[0] && !wr_tmr_w[0] && !wr_mode_w[0] |=> $stable(cnt_q[0]);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold)
    else $error("counter moved while stopped");

  property p_capture;
    edge_w[1] |=> cnt_q[1] == 16'h0000 && reload_q[1] == $past(cnt_q[1]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("edge did not capture and clear the counter");

  property p_first_edge_quiet;
    edge_w[1] && edges_q[1] == 2'd0 |=> !irq_req[1];
  endproperty
  a_first_edge_quiet: assert property (p_first_edge_quiet)
    else $error("first edge raised an interrupt");

  property p_overflow;
    ovf_ev_w[0] |=> irq_req[0] && ovf_q[0] && cnt_q[0] == 16'h0000;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged");

  property p_ovf_clear;
    wr_mode_w[0] && start_q[0] && !ovf_ev_w[0] |=> !ovf_q[0];
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("mode write did not clear overflow flag");

  property p_meas_no_write;
    meas_w[1] && wr_tmr_w[1] && !edge_w[1] |=> $stable(reload_q[1]);
  endproperty
  a_meas_no_write: assert property (p_meas_no_write)
    else $error("measurement result changed by a write");

  property p_read_timer;
    rd_stb && reg_hit(addr, 0, GTB_TMR_OFS) |=> rdata[15:0] ==
      ($past(meas_w[0]) ? $past(reload_q[0]) : $past(cnt_q[0]))
      ##1 ($past(rd_stb) || rdata == '0); // a back-to-back read keeps data up
  endproperty
  a_read_timer: assert property (p_read_timer)
    else $error("timer read returned the wrong value");

  c_underflow: cover property (down_w[0] && uf_w[0]);
  c_event_pin: cover property (mode_q[1].opmode == GTB_M_EVENT && tick_w[1]);
  c_second_edge: cover property (edge_w[1] && edges_q[1] == 2'd1);
  c_overflow: cover property (ovf_ev_w[0]);

endmodule

// ---- verification/gtb_pulse_src.sv ----
// gtb_pulse_src: far-side pulse source for one timer input pin
// assumes go is a one-cycle request; pin rests low between bursts
`timescale 1ns/1ps

module gtb_pulse_src (
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] npulse,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  output logic pin,
  output logic busy
);
  // ---------------------------------------------------------------------------
  // burst generator
  // ---------------------------------------------------------------------------
  logic [7:0] cnt_q;
  logic [3:0] left_q;

  // each pulse is hi_len cycles high then lo_len low, so period and width are exact
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin <= 1'b0;
      cnt_q <= 8'h00;
      left_q <= 4'h0;
    end else if (go) begin
      pin <= 1'b1;
      cnt_q <= hi_len - 8'h01;
      left_q <= npulse;
    end else if (left_q != 4'h0) begin
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (pin) begin
        pin <= 1'b0;
        cnt_q <= lo_len - 8'h01;
      end else begin
        left_q <= left_q - 4'h1;
        pin <= (left_q > 4'h1);  // last pulse leaves the pin low, no stray edge
        cnt_q <= hi_len - 8'h01;
      end
    end
  end

  assign busy = (left_q != 4'h0);
endmodule

// ---- verification/gtb_timer_test.sv ----
// gtb_timer_test: register-level bench for the six-channel timer block
// assumes the pulse source drives channel 1's pin; other pins rest low
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module gtb_timer_test;
  import gtb_pkg::*;
  // ---------------------------------------------------------------------------
  // stimulus and harness
  // ---------------------------------------------------------------------------
  logic mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0, subclk = 0, go = 0, src_pin, busy;
  logic [GTB_AW-1:0] addr = '0;
  logic [GTB_DW-1:0] wdata = '0, rdata, d;
  logic [GTB_NCH-1:0] irq_req;
  logic [3:0] npulse = 4'h0;
  logic [7:0] hi_len = 8'h01, lo_len = 8'h01;
  int failures = 0, checks = 0, n, meas_irqs = 0;
  int div_cyc[4] = '{1, 8, 32, 1280};  // subclock runs 40 mclk per period

  initial forever #12.5 mclk = ~mclk;
  initial forever #500 subclk = ~subclk;
  always @(posedge mclk) if (irq_req[1]) meas_irqs++;

  gtb_timer dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .subclk(subclk),
    .event_input_pin({4'h0, src_pin, 1'b0}), .irq_req(irq_req));
  gtb_pulse_src src (.mclk(mclk), .rst(rst), .go(go), .npulse(npulse), .hi_len(hi_len),
    .lo_len(lo_len), .pin(src_pin), .busy(busy));

  task automatic conclude;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic note(input string s);
    $display("test %s done checks=%0d failures=%0d", s, checks, failures);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= {16'h0000, v};
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // read data is taken only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // n ends as the cycle count since this call began
  task automatic wait_irq(input int ch);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (irq_req[ch] !== 1'b1 && n < 70000);
    if (n >= 70000) begin failures++; conclude(); end
  endtask

  task automatic pulses(input logic [3:0] k, input logic [7:0] h, input logic [7:0] l);
    @(posedge mclk);
    go <= 1'b1;
    npulse <= k;
    hi_len <= h;
    lo_len <= l;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    for (n = 0; n < 2000 && busy; n++) @(posedge mclk);
    if (busy) begin failures++; conclude(); end
    repeat (8) @(posedge mclk);  // let the pin synchroniser drain
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h00); `CHK(d, 32'h0000_0000)
    rd(8'h14); `CHK(d, 32'h0000_0000)
    rd(8'h70); `CHK(d, 32'h0000_0000)
    wr(8'h00, 16'h0003);
    rd(8'h00); `CHK(d[15:0], 16'h0003)
    wr(8'h60, 16'h0001);
    wait_irq(0); wait_irq(0); `CHK(n, 4)
    wr(8'h00, 16'h0005);
    wait_irq(0); wait_irq(0); `CHK(n, 6)
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, 16'(k) << 6);
      wait_irq(0); wait_irq(0); `CHK(n, 6 * div_cyc[k])
    end
    note("timer");
    // channel 1 counts underflows of channel 0
    wr(8'h04, 16'h0000);
    wr(8'h14, 16'h0011);
    wr(8'h10, 16'h0001);
    wr(8'h60, 16'h0003);
    wait_irq(1); wait_irq(1); `CHK(n, 12)
    for (int e = 0; e < 3; e++) begin
      wr(8'h60, 16'h0000);
      wr(8'h14, (16'(e) << 2) | 16'h0001);
      wr(8'h10, 16'h0009);
      wr(8'h60, 16'h0002);
      pulses(4'h3, 8'h04, 8'h04);
      rd(8'h10); `CHK(d[15:0], (e == 2) ? 16'h0003 : 16'h0006)
    end
    note("event");
    wr(8'h60, 16'h0000);
    wr(8'h14, 16'h0202);
    meas_irqs = 0;
    wr(8'h60, 16'h0002);
    pulses(4'h3, 8'h0a, 8'h1e);
    `CHK(meas_irqs, 2)
    rd(8'h10); `CHK(d[15:0], 16'h0027)
    wr(8'h10, 16'h1234);
    rd(8'h10); `CHK(d[15:0], 16'h0027)
    rd(8'h14); `CHK(d[10], 1'b1)
    wr(8'h60, 16'h0000);
    wr(8'h14, 16'h0102);
    meas_irqs = 0;
    wr(8'h60, 16'h0002);
    pulses(4'h3, 8'h0a, 8'h1e);
    `CHK(meas_irqs, 5)
    rd(8'h10); `CHK(d[15:0], 16'h0009)
    wr(8'h60, 16'h0000);
    note("measure");
    // channel 0's pin is tied low, so from zero its counter must run past the top
    wr(8'h00, 16'h0000);
    // the idle mode must ignore a timer write
    wr(8'h04, 16'h0003);
    wr(8'h00, 16'h0042);
    rd(8'h00); `CHK(d[15:0], 16'h0000)
    wr(8'h04, 16'h0002);
    wr(8'h60, 16'h0001);
    wait_irq(0); `CHK(n >= 65536 && n <= 65540, 1'b1)
    rd(8'h04); `CHK(d[5], 1'b1)
    wr(8'h04, 16'h0002);
    rd(8'h04); `CHK(d[5], 1'b0)
    wr(8'h60, 16'h0000);
    note("overflow");
    conclude();
  end
endmodule
